//--- aiomc_pkg.sv
// Purpose: Shared constants and types for the analog I/O module control block
// Assumes: One 100 MHz module clock, asynchronous active-high reset
// Notes: Long cycle counts are also top-level parameters so simulation can shorten them
package aiomc_pkg;

  // ---------------------------------------------------------------
  // Widths and channel counts
  // ---------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam int NCH = 4;
  localparam int CH_W = 2;
  localparam int AVG_LOG2 = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] RST_CODE = 16'h0000;
  localparam logic [CH_W-1:0] RST_CH = 2'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    LED_OFF    = 4'b0001,
    LED_GREEN  = 4'b0010,
    LED_ORANGE = 4'b0100,
    LED_RED    = 4'b1000
  } aiomc_led_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } aiomc_life_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b01,
    CV_WAIT = 2'b10
  } aiomc_conv_t;

  typedef struct packed {
    logic held;
    logic signed [CODE_W-1:0] value;
    logic signed [CODE_W-1:0] max;
    logic signed [CODE_W-1:0] min;
  } aiomc_ain_rpt_t;

  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [CODE_W-1:0] code;
  } aiomc_dac_cmd_t;

endpackage : aiomc_pkg

//--- aiomc_chan.sv
// Purpose: One analog input channel: plain sample, mean of several, max/min hold
// Assumes: sample_valid_in is a one-cycle pulse from the conversion sequencer
// Notes: Max/min always track raw samples, also while averaging
module aiomc_chan (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic sample_valid_in,
  input wire logic signed [aiomc_pkg::CODE_W-1:0] sample_in,
  input wire logic avg_en_in,
  input wire logic hold_en_in,
  input wire logic hold_restart_in,
  output logic rpt_valid_out,
  output aiomc_pkg::aiomc_ain_rpt_t rpt_out
);
  import aiomc_pkg::*;

  localparam int ACC_W = CODE_W + AVG_LOG2;

  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] sum;
  logic [AVG_LOG2-1:0] cnt_r;
  logic first_r;
  logic fresh;
  logic last;
  logic held_r;
  logic signed [CODE_W-1:0] value_r;
  logic signed [CODE_W-1:0] max_r;
  logic signed [CODE_W-1:0] min_r;

  assign sum = acc_r + ACC_W'(sample_in);
  assign last = (cnt_r == {AVG_LOG2{1'b1}});
  // A sample in the restart cycle already counts as the first one
  assign fresh = first_r || hold_restart_in;
  // One register per field keeps each field with a single writer
  assign rpt_out = {held_r, value_r, max_r, min_r};

  // ---------------------------------------------------------------
  // Averaging
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= '0;
      cnt_r <= '0;
    end else if (!avg_en_in) begin
      acc_r <= '0;
      cnt_r <= '0;
    end else if (sample_valid_in) begin
      acc_r <= last ? '0 : sum;
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Report register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rpt_valid_out <= 1'b0;
      value_r <= RST_CODE;
      held_r <= 1'b0;
    end else begin
      rpt_valid_out <= sample_valid_in && (!avg_en_in || last);
      held_r <= hold_en_in;
      if (sample_valid_in && !avg_en_in) begin
        value_r <= sample_in;
      end else if (sample_valid_in && last) begin
        value_r <= sum[ACC_W-1:AVG_LOG2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Max/min hold, restarted by reset or re-selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      first_r <= 1'b1;
      max_r <= RST_CODE;
      min_r <= RST_CODE;
    end else if (sample_valid_in && hold_en_in) begin
      first_r <= 1'b0;
      if (fresh || sample_in > max_r) begin
        max_r <= sample_in;
      end
      if (fresh || sample_in < min_r) begin
        min_r <= sample_in;
      end
    end else if (hold_restart_in) begin
      first_r <= 1'b1;
    end
  end

  a_plain_sample: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (sample_valid_in && !avg_en_in) |=> (rpt_valid_out && rpt_out.value == $past(sample_in)))
    else $error("plain sample not reported next cycle");

  a_hold_order: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (hold_en_in && !first_r && $past(hold_en_in)) |-> (rpt_out.max >= rpt_out.min))
    else $error("held maximum below held minimum");

endmodule : aiomc_chan

//--- aiomc_top.sv
// Purpose: Control of a four-in, four-out analog I/O extension module
// Assumes: Controller-side signals are on clk_sys_in; supply and watchdog flags are pins
// Notes: Converters are driven through start/done and load/ready handshakes
//
// Functional notes
// - Every input sample and output setting is a 16-bit code.
// - Four input channels, each from the ten or five volt range.
// - Four output channels, each driven from its own code.
// - Converted value of each enabled input goes to the controller.
// - Controller supplies each output value; device loads it into that converter.
// - With averaging, report the mean of several conversions, not single samples.
// - With hold, track and report largest and smallest values per input.
// - Run indicator green when powered properly, orange initialising, else dark.
// - Fault indicator blinks red on warning, steady red on alarm.
// - Fault indicator orange while initialising, dark in normal running.
// - Both indicators orange from power-on until initialisation ends.
// - Watchdog error forces both indicators steady red over everything.
// - No conversion of any kind starts without analog supply.
// - Alarm raised when analog supply was absent as control supply came up.
// - Controller setting selects ten or five volt input range per module.
module aiomc_top #(
  parameter int unsigned INIT_CYC = aiomc_pkg::INIT_CYCLES,
  parameter int unsigned BLINK_CYC = aiomc_pkg::BLINK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ana_supply_ok_in,
  input wire logic ctrl_supply_ok_in,
  input wire logic watchdog_err_in,
  input wire logic warning_in,
  input wire logic alarm_in,
  input wire logic input_range_setting_in,
  input wire logic avg_en_in,
  input wire logic hold_en_in,
  input wire logic [aiomc_pkg::NCH-1:0] ain_en_in,
  output logic adc_start_out,
  output logic [aiomc_pkg::CH_W-1:0] adc_ch_out,
  output logic adc_range_5v_out,
  input wire logic adc_done_in,
  input wire logic signed [aiomc_pkg::CODE_W-1:0] adc_data_in,
  output logic [aiomc_pkg::NCH-1:0] ain_valid_out,
  output aiomc_pkg::aiomc_ain_rpt_t [aiomc_pkg::NCH-1:0] ain_rpt_out,
  input wire logic dac_wr_in,
  input wire aiomc_pkg::aiomc_dac_cmd_t dac_wr_cmd_in,
  input wire logic dac_ready_in,
  output logic dac_load_out,
  output aiomc_pkg::aiomc_dac_cmd_t dac_cmd_out,
  output logic power_order_alarm_out,
  output aiomc_pkg::aiomc_led_t run_led_out,
  output aiomc_pkg::aiomc_led_t err_led_out
);
  import aiomc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers: ana supply, ctrl supply, watchdog
  // ---------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic ana_ok;
  logic ctrl_ok;
  logic wdog;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {watchdog_err_in, ctrl_supply_ok_in, ana_supply_ok_in};
      sync2_r <= sync1_r;
    end
  end

  assign ana_ok = sync2_r[0];
  assign ctrl_ok = sync2_r[1];
  assign wdog = sync2_r[2];

  // ---------------------------------------------------------------
  // Initialisation and power order
  // ---------------------------------------------------------------
  aiomc_life_t life_r;
  logic [31:0] init_cnt_r;
  logic ctrl_seen_r;
  logic running;

  assign running = (life_r == ST_RUN);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      life_r <= ST_INIT;
      init_cnt_r <= 32'h0;
    end else begin
      case (life_r)
        ST_INIT: begin
          if (ctrl_ok) begin
            init_cnt_r <= init_cnt_r + 32'h1;
            if (init_cnt_r >= INIT_CYC - 1) begin
              life_r <= ST_RUN;
            end
          end
        end
        default: life_r <= ST_RUN;
      endcase
    end
  end

  // The alarm is sticky: only a reset clears a bad power-up order
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_seen_r <= 1'b0;
      power_order_alarm_out <= 1'b0;
    end else if (ctrl_ok && !ctrl_seen_r) begin
      ctrl_seen_r <= 1'b1;
      power_order_alarm_out <= !ana_ok;
    end
  end

  // ---------------------------------------------------------------
  // Input conversion sequencer
  // ---------------------------------------------------------------
  aiomc_conv_t cv_r;
  logic [CH_W-1:0] cv_ch_r;
  logic [NCH-1:0] samp_v_r;
  logic signed [CODE_W-1:0] samp_r;
  logic conv_ok;

  assign conv_ok = running && ana_ok;
  assign adc_ch_out = cv_ch_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cv_r <= CV_IDLE;
      cv_ch_r <= RST_CH;
      adc_start_out <= 1'b0;
      samp_v_r <= '0;
      samp_r <= RST_CODE;
    end else begin
      adc_start_out <= 1'b0;
      samp_v_r <= '0;
      case (cv_r)
        CV_IDLE: begin
          if (conv_ok && ain_en_in[cv_ch_r]) begin
            adc_start_out <= 1'b1;
            cv_r <= CV_WAIT;
          end else if (conv_ok) begin
            cv_ch_r <= cv_ch_r + 1'b1;
          end
        end
        CV_WAIT: begin
          if (!ana_ok) begin
            cv_r <= CV_IDLE; // Conversion result is meaningless without supply
          end else if (adc_done_in) begin
            samp_v_r[cv_ch_r] <= 1'b1;
            samp_r <= adc_data_in;
            cv_ch_r <= cv_ch_r + 1'b1;
            cv_r <= CV_IDLE;
          end
        end
        default: cv_r <= CV_IDLE;
      endcase
    end
  end

  // Range follows the controller setting; changes apply to the next start
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      adc_range_5v_out <= 1'b0;
    end else if (cv_r == CV_IDLE) begin
      adc_range_5v_out <= input_range_setting_in;
    end
  end

  // ---------------------------------------------------------------
  // Per-channel processing
  // ---------------------------------------------------------------
  logic hold_d_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hold_d_r <= 1'b0;
    end else begin
      hold_d_r <= hold_en_in;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    aiomc_chan u_chan (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .sample_valid_in(samp_v_r[i]),
      .sample_in(samp_r),
      .avg_en_in(avg_en_in),
      .hold_en_in(hold_en_in),
      .hold_restart_in(hold_en_in && !hold_d_r),
      .rpt_valid_out(ain_valid_out[i]),
      .rpt_out(ain_rpt_out[i])
    );
  end

  // ---------------------------------------------------------------
  // Output converter loading
  // ---------------------------------------------------------------
  logic [NCH-1:0] dac_pend_r;
  logic [NCH-1:0][CODE_W-1:0] dac_code_r;
  logic [CH_W-1:0] pick;
  logic found;
  logic issue;

  always_comb begin
    pick = RST_CH;
    found = 1'b0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (dac_pend_r[k]) begin
        pick = CH_W'(k);
        found = 1'b1;
      end
    end
  end

  assign issue = found && running && ana_ok && dac_ready_in;

  // A new write in the issue cycle keeps the channel pending
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dac_pend_r <= '0;
      dac_code_r <= '0;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (dac_wr_in && dac_wr_cmd_in.ch == CH_W'(k)) begin
          dac_pend_r[k] <= 1'b1;
          dac_code_r[k] <= dac_wr_cmd_in.code;
        end else if (issue && pick == CH_W'(k)) begin
          dac_pend_r[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dac_load_out <= 1'b0;
      dac_cmd_out <= '0;
    end else begin
      dac_load_out <= issue;
      if (issue) begin
        dac_cmd_out.ch <= pick;
        dac_cmd_out.code <= dac_code_r[pick];
      end
    end
  end

  // ---------------------------------------------------------------
  // Indicators
  // ---------------------------------------------------------------
  logic [31:0] blink_cnt_r;
  logic blink_r;
  aiomc_led_t run_nxt;
  aiomc_led_t err_nxt;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h0;
      blink_r <= !blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  always_comb begin
    if (wdog) begin
      run_nxt = LED_RED;
      err_nxt = LED_RED;
    end else if (!running) begin
      run_nxt = LED_ORANGE;
      err_nxt = LED_ORANGE;
    end else begin
      run_nxt = (ctrl_ok && !power_order_alarm_out) ? LED_GREEN : LED_OFF;
      if (alarm_in || power_order_alarm_out) begin
        err_nxt = LED_RED;
      end else if (warning_in) begin
        err_nxt = blink_r ? LED_RED : LED_OFF;
      end else begin
        err_nxt = LED_OFF;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      run_led_out <= LED_ORANGE;
      err_led_out <= LED_ORANGE;
    end else begin
      run_led_out <= run_nxt;
      err_led_out <= err_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_ctrl_up_bad;
    ctrl_ok && !ctrl_seen_r && !ana_ok;
  endsequence

  sequence s_alarm_held;
    power_order_alarm_out [*3];
  endsequence

  a_power_order: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_ctrl_up_bad |=> s_alarm_held)
    else $error("power order alarm not raised and held");

  a_adc_gated: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    adc_start_out |-> $past(ana_ok) && $past(running))
    else $error("conversion started without analog supply");

  a_dac_gated: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    dac_load_out |-> $past(ana_ok) && $past(dac_ready_in))
    else $error("output load without supply or ready");

  a_dac_code: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (dac_wr_in && !found) ##1 issue
      |=> (dac_load_out && dac_cmd_out == $past(dac_wr_cmd_in, 2)))
    else $error("written output code not loaded two cycles later");

  a_wdog_red: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wdog |=> (run_led_out == LED_RED && err_led_out == LED_RED))
    else $error("watchdog did not force both indicators red");

  a_init_orange: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (!running && !wdog) |=> (run_led_out == LED_ORANGE && err_led_out == LED_ORANGE))
    else $error("indicators not orange during initialisation");

  a_alarm_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (running && !wdog && alarm_in && warning_in) |=> (err_led_out == LED_RED))
    else $error("alarm with warning not steady red");

  a_normal_dark: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (running && !wdog && !alarm_in && !warning_in && !power_order_alarm_out)
      |=> (err_led_out == LED_OFF))
    else $error("fault indicator lit in normal running");

  a_one_outstanding: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (adc_start_out && ana_ok) |=> (!adc_start_out && cv_r == CV_WAIT))
    else $error("second conversion started before completion");

endmodule : aiomc_top

//--- aiomc_conv_model.sv
// Purpose: Far-side model of the input and output converters seen by the control block
// Assumes: One clock shared with the block; latency and stall are set by the bench
// Notes: Data wiggles every cycle while not valid so a late sample never matches
module aiomc_conv_model #(
  parameter logic [63:0] BASES = 64'h0
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [1:0] ch_in,
  input wire logic [3:0] lat_in,
  input wire logic stall_in,
  output logic done_out,
  output logic signed [15:0] data_out,
  output logic ready_out
);
  logic [3:0] cnt_r;
  logic [1:0] ch_r;
  logic [3:0] tog_r;

  // ---------------------------------------------------------------
  // Input converter: answers lat_in + 1 cycles after a start
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      ch_r <= 2'h0;
      tog_r <= 4'h0;
      done_out <= 1'b0;
      data_out <= 16'h5a5a;
    end else begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (start_in) begin
        cnt_r <= lat_in;
        ch_r <= ch_in;
      end else if (cnt_r == 4'h1) begin
        // Alternating samples make every mean of four and the max/min predictable
        cnt_r <= 4'h0;
        done_out <= 1'b1;
        data_out <= BASES[ch_r*16 +: 16] + (tog_r[ch_r] ? 16'h0008 : 16'h0000);
        tog_r[ch_r] <= ~tog_r[ch_r];
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output converter: accepts loads unless the bench stalls it
  // ---------------------------------------------------------------
  assign ready_out = ~stall_in;
endmodule : aiomc_conv_model

//--- aiomc_tb_top.sv
// Purpose: Self-checking bench of the analog I/O module control block
// Assumes: Short init and blink counts; converter model on the far side
// Notes: Each scenario is a task that drives and judges its own traffic
module aiomc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aiomc_pkg::*;
  localparam logic [63:0] BASES = 64'hff00_7ff0_0400_1230;
  logic clk_sys_in = 0, rst_in = 1, ana_ok = 1, ctrl_ok = 0, wd = 0, warn = 0, alm = 0;
  logic rng = 0, avg = 0, hold = 0, dac_wr = 0, stall = 0, start, range5, done, ready;
  logic load, po_alm;
  logic [3:0] ain_en = 4'hf, valid, lat = 4'h3;
  logic [1:0] ch;
  logic signed [15:0] data;
  aiomc_ain_rpt_t [3:0] rpt;
  aiomc_dac_cmd_t wcmd = '0, cmd;
  aiomc_led_t run_led, err_led;
  int failures = 0, tests_run = 0;
  wire [5:0] mon = {start, load, valid};

  always #5 clk_sys_in = ~clk_sys_in;

  aiomc_top #(.INIT_CYC(20), .BLINK_CYC(8)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ana_supply_ok_in(ana_ok),
    .ctrl_supply_ok_in(ctrl_ok), .watchdog_err_in(wd), .warning_in(warn), .alarm_in(alm),
    .input_range_setting_in(rng), .avg_en_in(avg), .hold_en_in(hold), .ain_en_in(ain_en),
    .adc_start_out(start), .adc_ch_out(ch), .adc_range_5v_out(range5), .adc_done_in(done),
    .adc_data_in(data), .ain_valid_out(valid), .ain_rpt_out(rpt), .dac_wr_in(dac_wr),
    .dac_wr_cmd_in(wcmd), .dac_ready_in(ready), .dac_load_out(load), .dac_cmd_out(cmd),
    .power_order_alarm_out(po_alm), .run_led_out(run_led), .err_led_out(err_led)
  );

  aiomc_conv_model #(.BASES(BASES)) u_conv (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start), .ch_in(ch), .lat_in(lat),
    .stall_in(stall), .done_out(done), .data_out(data), .ready_out(ready)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task test_done;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  // Bounded wait for a pulse on one monitored bit; a hang ends the run
  task wait_hi(input int b);
    int i;
    for (i = 0; i < 400; i++) begin
      cyc(1);
      if (mon[b] === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, mon, 6'h1 << b);
      test_done();
    end
  endtask : wait_hi

  task count(input int b, input int len, output int n);
    n = 0;
    repeat (len) begin
      cyc(1);
      n += (mon[b] === 1'b1);
    end
  endtask : count

  task power_up(input logic ana_first);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    ana_ok <= ana_first;
    ctrl_ok <= 1'b0;
    cyc(5);
    @(posedge clk_sys_in) rst_in <= 1'b0;
    cyc(3);
    chk(run_led, LED_ORANGE);
    chk(err_led, LED_ORANGE);
    @(posedge clk_sys_in) ctrl_ok <= 1'b1;
    cyc(6);
    chk(run_led, LED_ORANGE);
    @(posedge clk_sys_in) ana_ok <= 1'b1;
  endtask : power_up

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_order;
    power_up(1'b0);
    cyc(40);
    chk(po_alm, 1'b1);
    chk(run_led, LED_OFF);
    chk(err_led, LED_RED);
    $display("t_order finished");
  endtask : t_order

  task t_init;
    int i;
    power_up(1'b1);
    for (i = 0; i < 60 && run_led !== LED_GREEN; i++) cyc(1);
    chk(run_led, LED_GREEN);
    chk(err_led, LED_OFF);
    chk(po_alm, 1'b0);
    $display("t_init finished");
  endtask : t_init

  task t_plain;
    int n, m;
    logic [15:0] b;
    @(posedge clk_sys_in) rng <= 1'b1;
    ain_en <= 4'b1011;
    lat <= 4'h8;
    cyc(30);
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      b = BASES[c*16 +: 16];
      wait_hi(c);
      chk((rpt[c].value === b) || (rpt[c].value === b + 16'h0008), 1'b1);
      chk(rpt[c].held, 1'b0);
      chk(range5, 1'b1);
    end
    count(2, 120, n);
    chk(n, 0);
    @(posedge clk_sys_in) rng <= 1'b0;
    ain_en <= 4'hf;
    count(5, 60, m);
    chk(m > 3, 1'b1);
    chk(range5, 1'b0);
    $display("t_plain finished");
  endtask : t_plain

  task t_avg;
    @(posedge clk_sys_in) avg <= 1'b1;
    lat <= 4'h1;
    for (int c = 0; c < 4; c++) begin
      wait_hi(c);
      wait_hi(c);
      chk($unsigned(rpt[c].value), BASES[c*16 +: 16] + 16'h0004);
    end
    @(posedge clk_sys_in) avg <= 1'b0;
    $display("t_avg finished");
  endtask : t_avg

  task t_hold;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys_in) hold <= 1'b0;
      cyc(10);
      @(posedge clk_sys_in) hold <= 1'b1;
      wait_hi(c);
      chk({rpt[c].max, rpt[c].min}, {rpt[c].value, rpt[c].value});
      wait_hi(c);
      wait_hi(c);
      chk($unsigned(rpt[c].max), BASES[c*16 +: 16] + 16'h0008);
      chk($unsigned(rpt[c].min), BASES[c*16 +: 16]);
      chk(rpt[c].held, 1'b1);
    end
    @(posedge clk_sys_in) hold <= 1'b0;
    $display("t_hold finished");
  endtask : t_hold

  task t_dac;
    int n;
    @(posedge clk_sys_in) stall <= 1'b1;
    // Highest channel written first, so issue order is the device's own choice
    for (int c = 3; c >= 0; c--) begin
      @(posedge clk_sys_in) dac_wr <= 1'b1;
      wcmd <= {2'(c), 16'h8001 + 16'(c) * 16'h1110};
    end
    @(posedge clk_sys_in) dac_wr <= 1'b0;
    count(4, 12, n);
    chk(n, 0);
    @(posedge clk_sys_in) stall <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wait_hi(4);
      chk(cmd, {2'(c), 16'h8001 + 16'(c) * 16'h1110});
    end
    // A lone write from idle must load exactly two cycles after it is taken
    @(posedge clk_sys_in) dac_wr <= 1'b1;
    wcmd <= {2'h2, 16'h1234};
    @(posedge clk_sys_in) dac_wr <= 1'b0;
    cyc(1);
    chk({load, cmd}, {1'b1, 2'h2, 16'h1234});
    $display("t_dac finished");
  endtask : t_dac

  task t_supply;
    int n, m;
    @(posedge clk_sys_in) ana_ok <= 1'b0;
    cyc(6);
    @(posedge clk_sys_in) dac_wr <= 1'b1;
    wcmd <= {2'h1, 16'h7ffe};
    @(posedge clk_sys_in) dac_wr <= 1'b0;
    count(5, 40, n);
    count(4, 40, m);
    chk({n, m}, 64'h0);
    @(posedge clk_sys_in) ana_ok <= 1'b1;
    wait_hi(4);
    chk(cmd, {2'h1, 16'h7ffe});
    wait_hi(5);
    chk(start, 1'b1);
    $display("t_supply finished");
  endtask : t_supply

  task t_leds;
    int r, o;
    r = 0;
    o = 0;
    @(posedge clk_sys_in) warn <= 1'b1;
    repeat (40) begin
      cyc(1);
      r += (err_led === LED_RED);
      o += (err_led === LED_OFF);
    end
    chk(r > 0 && o > 0, 1'b1);
    @(posedge clk_sys_in) alm <= 1'b1;
    cyc(3);
    r = 0;
    repeat (20) begin
      cyc(1);
      r += (err_led === LED_RED);
    end
    chk(r, 20);
    @(posedge clk_sys_in) wd <= 1'b1;
    cyc(6);
    chk({run_led, err_led}, {LED_RED, LED_RED});
    @(posedge clk_sys_in) wd <= 1'b0;
    alm <= 1'b0;
    warn <= 1'b0;
    cyc(6);
    chk({run_led, err_led}, {LED_GREEN, LED_OFF});
    $display("t_leds finished");
  endtask : t_leds

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    t_order();
    t_init();
    t_plain();
    t_avg();
    t_hold();
    t_dac();
    t_supply();
    t_leds();
    test_done();
  end
endmodule : aiomc_tb_top
